//--- verilog/psrt_defs.svh
`ifndef PSRT_DEFS_SVH
`define PSRT_DEFS_SVH
// ==========================================================
// Register map (byte addresses, AXI4-Lite)
`define PSRT_ADDR_LVDCTL   12'h000
`define PSRT_ADDR_CFG      12'h004
`define PSRT_ADDR_STATUS   12'h008
// Control register fields
`define PSRT_TRIP_LSB      0
`define PSRT_PWR_ON_BIT    4
`define PSRT_REF_STB_BIT   5
`define PSRT_TRIP_RESET    4'h5
`define PSRT_TRIP_EXT      4'hF
`define PSRT_TRIP_RSV1     4'h1
// Configuration register fields
`define PSRT_CFG_BOR_BIT   0
`define PSRT_CFG_SOFT_BIT  1
`define PSRT_CFG_SWEN_BIT  2
`define PSRT_CFG_PWRTN_BIT 3
`define PSRT_CFG_IRQEN_BIT 4
`define PSRT_CFG_GIE_BIT   5
`define PSRT_CFG_RESET     8'h08
// Status register fields
`define PSRT_ST_FLAG_BIT   0
`define PSRT_ST_CORE_BIT   1
`define PSRT_ST_SLEEP_BIT  2
// Timing
`define PSRT_CLK_MHZ       200
`define PSRT_OST_CYCLES    1024
`define PSRT_BOR_MIN_US    100
`define PSRT_BOR_MIN_CYC   (`PSRT_BOR_MIN_US * `PSRT_CLK_MHZ)
`define PSRT_POWERUP_DELAY_TIMER_MS       72
`define PSRT_POWERUP_DELAY_TIMER_CYC      (`PSRT_POWERUP_DELAY_TIMER_MS * 1000 * `PSRT_CLK_MHZ)
`define PSRT_REF_MAX_US    50
`define PSRT_REF_CYC       (`PSRT_REF_MAX_US * `PSRT_CLK_MHZ)
`endif

//--- verilog/psrt_pkg.sv
package psrt_pkg;
	// Reset sequencer states
	typedef enum logic [2:0] {
		ST_POWERUP_DELAY_TIMER,
		ST_OST,
		ST_RUN,
		ST_BROWN
	} psrt_state_t;
	// Oscillator mode select
	typedef enum logic [2:0] {
		OSC_LOW_POWER,
		OSC_MEDIUM,
		OSC_HIGH_SPEED,
		OSC_EXT_CLOCK,
		OSC_INT_RC
	} psrt_osc_t;
endpackage

//--- verilog/psrt_top.sv
`timescale 1ns/1ps
`include "psrt_defs.svh"
// Overview of operation
// - Count 1024 oscillator input cycles after power-up delay, holding reset.
// - Start-up count only in crystal modes, on power-on, brown-out recovery or sleep wake.
// - Brown-out mode from config, soft config and software enable bits.
// - Modes: 11 always, 10 off in sleep, 01 software, 00 disabled.
// - Reset after brown-out persists beyond about 100 us.
// - Hold reset while low, then power-up delay of 72 ms if enabled.
// - A new dip during the delay restarts the whole sequence.
// - Power-up timer enable is independent of brown-out enable.
// - Power-up delay from internal counter; enable bit is active low.
// - Set low-voltage flag when selected tap is below the reference.
// - Trip level in control bits 3..0; codes 0000 and 0001 reserved.
// - Code 1111 senses the external input instead of the divider.
// - Flag with its interrupt and global interrupt enables set requests an interrupt when not asleep.
// - Bit 4 powers the detector; bit 5 read-only reference stable.
// - Flag only takes effect once the reference is stable.
// - Reference stable no more than 50 us after detector power-on.
// - Detector works in sleep; crossing sets flag and wakes the core.
// - Only sys_rst returns registers to reset, detector off; pin and brown-out resets keep them.
// - Power-on skips the delay (enable_n set at reset), runs start-up count in crystal modes before leaving reset.
// - With master clear held past all delays, release starts at once.
module psrt_top #(
	parameter int unsigned POWERUP_DELAY_TIMER_CYC = `PSRT_POWERUP_DELAY_TIMER_CYC,  // Power-up delay
	parameter int unsigned REF_CYC  = `PSRT_REF_CYC    // Reference settle
) (
	input  wire logic             clock,             // 200 MHz clock
	input  wire logic             sys_rst,           // Power-on reset
	input  wire logic             master_clear_n,    // External reset pin
	input  wire logic             oscillator_input,  // Oscillator pin
	input  wire psrt_pkg::psrt_osc_t osc_mode,       // Oscillator mode
	input  wire logic             brownout_cmp,      // Supply below level
	input  wire logic             lv_tap_cmp,        // Divider tap low
	input  wire logic             lv_ext_cmp,        // External sense low
	input  wire logic             sleep_req,         // Core enters sleep
	output logic                  core_reset,        // Hold core in reset
	output logic                  core_irq,          // Interrupt request
	output logic                  core_wake,         // Wake from sleep
	output logic                  detector_power,    // Analog power on
	output logic                  ext_sense_sel,     // Use external input
	output logic [3:0]            trip_level_out,    // Divider tap select
	input  wire logic [11:0]      s_axi_awaddr,      // Write address
	input  wire logic             s_axi_awvalid,     // Write addr valid
	output logic                  s_axi_awready,     // Write addr ready
	input  wire logic [31:0]      s_axi_wdata,       // Write data
	input  wire logic [3:0]       s_axi_wstrb,       // Write strobes
	input  wire logic             s_axi_wvalid,      // Write data valid
	output logic                  s_axi_wready,      // Write data ready
	output logic [1:0]            s_axi_bresp,       // Write response
	output logic                  s_axi_bvalid,      // Write resp valid
	input  wire logic             s_axi_bready,      // Write resp ready
	input  wire logic [11:0]      s_axi_araddr,      // Read address
	input  wire logic             s_axi_arvalid,     // Read addr valid
	output logic                  s_axi_arready,     // Read addr ready
	output logic [31:0]           s_axi_rdata,       // Read data
	output logic [1:0]            s_axi_rresp,       // Read response
	output logic                  s_axi_rvalid,      // Read data valid
	input  wire logic             s_axi_rready       // Read data ready
);
	import psrt_pkg::*;

	// ==========================================================
	// State record
	typedef struct packed {
		psrt_state_t st;
		logic [31:0] cnt;        // Power-up delay counter
		logic [10:0] oscillator_startup_counter;        // Oscillator edge counter
		logic        ost_run;
		logic [15:0] bor_cnt;    // Brown-out persistence
		logic [15:0] ref_cnt;    // Reference settle counter
		logic        ref_stb;
		logic [3:0]  trip;
		logic        pwr_on;
		logic [7:0]  cfg;
		logic        flag;
		logic        sleeping;
		logic        osc_d;
		logic [1:0]  bor_s;      // Synchronisers
		logic [1:0]  tap_s;
		logic [1:0]  ext_s;
		logic        aw_got;
		logic [11:0] aw_a;
		logic        w_got;
		logic [31:0] w_d;
		logic [3:0]  w_s;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} psrt_regs_t;

	psrt_regs_t r_reg;
	psrt_regs_t r_next;
	logic       bor_active;
	logic       lv_low;
	logic       crystal;
	logic       wr_fire;
	logic       rd_fire;
	logic       osc_rise;

	localparam logic [15:0] BOR_MIN = 16'(`PSRT_BOR_MIN_CYC);
	localparam logic [10:0] OST_MAX = 11'(`PSRT_OST_CYCLES);

	// ==========================================================
	// Derived conditions
	always_comb begin
		// Brown-out mode decode from the two config bits
		case ({r_reg.cfg[`PSRT_CFG_BOR_BIT], r_reg.cfg[`PSRT_CFG_SOFT_BIT]})
		2'b11: bor_active = 1'b1;
		2'b10: bor_active = !r_reg.sleeping;
		2'b01: bor_active = r_reg.cfg[`PSRT_CFG_SWEN_BIT];
		default: bor_active = 1'b0;
		endcase
	end
	assign crystal = (osc_mode == OSC_LOW_POWER) || (osc_mode == OSC_MEDIUM)
		|| (osc_mode == OSC_HIGH_SPEED);
	// External sense on code 1111, otherwise divider tap
	assign lv_low = (r_reg.trip == `PSRT_TRIP_EXT) ?
		r_reg.ext_s[1] : r_reg.tap_s[1];
	assign osc_rise = r_reg.osc_d == 1'b0 && oscillator_input == 1'b1;
	assign wr_fire = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	// ==========================================================
	// Next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.osc_d = oscillator_input;
		// Two-stage synchronisers
		r_next.bor_s = {r_reg.bor_s[0], brownout_cmp};
		r_next.tap_s = {r_reg.tap_s[0], lv_tap_cmp};
		r_next.ext_s = {r_reg.ext_s[0], lv_ext_cmp};
		// Sleep tracking
		if (sleep_req && r_reg.st == ST_RUN)
			r_next.sleeping = 1'b1;
		// Brown-out persistence filter
		if (bor_active && r_reg.bor_s[1]) begin
			if (r_reg.bor_cnt != BOR_MIN)
				r_next.bor_cnt = r_reg.bor_cnt + 16'h0001;
		end else begin
			r_next.bor_cnt = 16'h0000;
		end
		// Reset sequencer
		case (r_reg.st)
		ST_POWERUP_DELAY_TIMER: begin
			// Power-up delay counts only when enable_n is low
			if (r_reg.cfg[`PSRT_CFG_PWRTN_BIT] ||
			    r_reg.cnt >= POWERUP_DELAY_TIMER_CYC - 1) begin
				r_next.cnt = 32'h0;
				r_next.st = crystal ? ST_OST : ST_RUN;
				r_next.oscillator_startup_counter = 11'h000;
			end else begin
				r_next.cnt = r_reg.cnt + 32'h1;
			end
		end
		ST_OST: begin
			if (osc_rise)
				r_next.oscillator_startup_counter = r_reg.oscillator_startup_counter + 11'h001;
			if (r_reg.oscillator_startup_counter == OST_MAX)
				r_next.st = ST_RUN;
		end
		ST_RUN: begin
			// Wake from sleep: start-up count in crystal modes
			if (r_reg.sleeping && r_reg.flag) begin
				r_next.sleeping = 1'b0;
				if (crystal) begin
					r_next.st = ST_OST;
					r_next.oscillator_startup_counter = 11'h000;
				end
			end
		end
		ST_BROWN: begin
			// Stay until supply recovers, then full sequence
			r_next.cnt = 32'h0;
			if (!r_reg.bor_s[1])
				r_next.st = ST_POWERUP_DELAY_TIMER;
		end
		default: r_next.st = ST_POWERUP_DELAY_TIMER;
		endcase
		if (r_reg.bor_cnt == BOR_MIN) begin
			r_next.st = ST_BROWN;
			r_next.sleeping = 1'b0;
		end
		// Reference settle timer
		if (!r_reg.pwr_on) begin
			r_next.ref_cnt = 16'h0000;
			r_next.ref_stb = 1'b0;
		end else if (r_reg.ref_cnt >= REF_CYC - 1) begin
			r_next.ref_stb = 1'b1;
		end else begin
			r_next.ref_cnt = r_reg.ref_cnt + 16'h0001;
		end
		// AXI write channel capture
		if (s_axi_awvalid && s_axi_awready) begin
			r_next.aw_got = 1'b1;
			r_next.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			r_next.w_got = 1'b1;
			r_next.w_d = s_axi_wdata;
			r_next.w_s = s_axi_wstrb;
		end
		if (wr_fire) begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = 2'b00;
			case (r_reg.aw_a)
			`PSRT_ADDR_LVDCTL: if (r_reg.w_s[0]) begin
				r_next.trip = r_reg.w_d[3:0];
				r_next.pwr_on = r_reg.w_d[`PSRT_PWR_ON_BIT];
			end
			`PSRT_ADDR_CFG: if (r_reg.w_s[0])
				r_next.cfg = r_reg.w_d[7:0];
			`PSRT_ADDR_STATUS: if (r_reg.w_s[0] &&
			    r_reg.w_d[`PSRT_ST_FLAG_BIT])
				r_next.flag = 1'b0;
			default: r_next.bresp = 2'b10;
			endcase
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		// Flag set wins over a software clear
		if (r_reg.pwr_on && r_reg.ref_stb && lv_low)
			r_next.flag = 1'b1;
		// AXI read
		if (rd_fire) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = 2'b00;
			r_next.rdata = 32'h0;
			case (s_axi_araddr)
			`PSRT_ADDR_LVDCTL: r_next.rdata = {26'h0, r_reg.ref_stb,
				r_reg.pwr_on, r_reg.trip};
			`PSRT_ADDR_CFG: r_next.rdata = {24'h0, r_reg.cfg};
			`PSRT_ADDR_STATUS: r_next.rdata = {29'h0, r_reg.sleeping,
				r_reg.st != ST_RUN, r_reg.flag};
			default: r_next.rresp = 2'b10;
			endcase
		end
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
	end

	// ==========================================================
	// State register; only sys_rst loads register reset values
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_reg <= '0;
			r_reg.st <= ST_POWERUP_DELAY_TIMER;
			r_reg.trip <= `PSRT_TRIP_RESET;
			r_reg.cfg <= `PSRT_CFG_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// Outputs
	// Pin release ends reset with no added delay
	assign core_reset = (r_reg.st != ST_RUN) || !master_clear_n;
	assign core_irq = r_reg.flag && r_reg.cfg[`PSRT_CFG_IRQEN_BIT]
		&& r_reg.cfg[`PSRT_CFG_GIE_BIT] && !r_reg.sleeping;
	assign core_wake = r_reg.sleeping && r_reg.flag;
	assign detector_power = r_reg.pwr_on;
	assign ext_sense_sel = r_reg.trip == `PSRT_TRIP_EXT;
	assign trip_level_out = r_reg.trip;
	assign s_axi_awready = !r_reg.aw_got;
	assign s_axi_wready = !r_reg.w_got;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rresp = r_reg.rresp;
	assign s_axi_rdata = r_reg.rdata;
endmodule

//--- tb/psrt_core_model.sv
`timescale 1ns/1ps
// ==========================================
// Core stand-in: sleeps on command, wakes on request
module psrt_core_model (
	input  wire logic clock,      // Clock
	input  wire logic sys_rst,    // Reset
	input  wire logic core_reset, // Core held
	input  wire logic core_wake,  // Wake request
	input  wire logic go_sleep,   // Bench sleep command
	output logic      sleep_req,  // Sleep pulse
	output logic      asleep      // Sleeping
);
	// Enter sleep only when running, leave on wake
	always_ff @(posedge clock) begin
		sleep_req <= !sys_rst && go_sleep && !core_reset && !asleep;
		if (sys_rst || core_reset || core_wake)
			asleep <= 1'b0;
		else if (sleep_req)
			asleep <= 1'b1;
	end
endmodule

//--- tb/psrt_top_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module psrt_chk (
	input wire logic                clock,            // Clock
	input wire logic                sys_rst,          // Reset
	input wire logic                master_clear_n,   // Reset pin
	input wire logic                oscillator_input, // Oscillator
	input wire psrt_pkg::psrt_osc_t osc_mode,         // Osc mode
	input wire logic                core_reset,       // Core held
	input wire logic                core_irq,         // Irq
	input wire logic                core_wake,        // Wake
	input wire logic                detector_power,   // Power
	input wire logic                ext_sense_sel,    // External
	input wire logic [3:0]          trip_level_out,   // Trip
	input wire logic [11:0]         s_axi_araddr,     // Read addr
	input wire logic                s_axi_arvalid,    // Addr valid
	input wire logic                s_axi_arready,    // Addr ready
	input wire logic [31:0]         s_axi_rdata,      // Read data
	input wire logic [1:0]          s_axi_rresp       // Read resp
);
	import psrt_pkg::*;
	logic [11:0] cnt;
	logic        osc_d;
	logic        ar;
	assign ar = s_axi_arvalid && s_axi_arready;
	// Oscillator rises seen while the core is held
	always_ff @(posedge clock) begin
		osc_d <= oscillator_input;
		if (sys_rst || !core_reset)
			cnt <= 12'h000;
		else if (oscillator_input && !osc_d && cnt != 12'hFFF)
			cnt <= cnt + 12'h001;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_reset_state: assert property (disable iff (1'b0)
		sys_rst |=> core_reset && !core_irq && !detector_power
		&& trip_level_out == 4'h5) else $error("reset state wrong");
	a_master_clear_n_hold: assert property (
		!master_clear_n |-> core_reset) else $error("pin reset lost");
	a_ext_route: assert property (
		ext_sense_sel == (trip_level_out == 4'hF))
		else $error("sense route wrong");
	a_wake_irq: assert property (
		core_wake |-> !core_irq) else $error("irq while asleep");
	a_ost_count: assert property (
		$fell(core_reset) && $past(master_clear_n)
		&& osc_mode <= OSC_HIGH_SPEED |-> cnt >= 12'h400)
		else $error("start-up count short");
	a_ctl_read: assert property (
		ar && s_axi_araddr == 12'h000 |=> s_axi_rdata[4:0] ==
		$past({detector_power, trip_level_out}))
		else $error("control readback wrong");
	a_ref_off: assert property (
		ar && s_axi_araddr == 12'h000 && !detector_power
		|=> !s_axi_rdata[5]) else $error("stable while off");
	a_rd_error: assert property (
		ar && s_axi_araddr[11:2] > 10'h002 |=> s_axi_rresp == 2'b10
		&& s_axi_rdata == 32'h0) else $error("unmapped read");
	c_release: cover property ($fell(core_reset));
	c_wake: cover property ($rose(core_wake));
	c_irq: cover property ($rose(core_irq));
endmodule
bind psrt_top psrt_chk psrt_chk_inst (.clock, .sys_rst, .master_clear_n,
	.oscillator_input, .osc_mode, .core_reset, .core_irq, .core_wake,
	.detector_power, .ext_sense_sel, .trip_level_out, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp);

//--- tb/psrt_top_tb.sv
`timescale 1ns/1ps
// ==========================================
// Power supervisor bench
module psrt_top_tb;
	import psrt_pkg::*;
	logic clock, sys_rst, master_clear_n, oscillator_input, brownout_cmp;
	logic lv_tap_cmp, lv_ext_cmp, sleep_req, core_reset, core_irq;
	logic core_wake, detector_power, ext_sense_sel, go_sleep, asleep;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [2:0] t;
	logic [3:0] trip_level_out, s_axi_wstrb;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, lfsr;
	psrt_osc_t osc_mode;
	int error_cnt, comparisons, c;
	psrt_top #(.POWERUP_DELAY_TIMER_CYC(50), .REF_CYC(20)) psrt_top_inst (.clock,
		.sys_rst, .master_clear_n, .oscillator_input, .osc_mode,
		.brownout_cmp, .lv_tap_cmp, .lv_ext_cmp, .sleep_req, .core_reset,
		.core_irq, .core_wake, .detector_power, .ext_sense_sel,
		.trip_level_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	psrt_core_model psrt_core_model_inst (.clock, .sys_rst, .core_reset,
		.core_wake, .go_sleep, .sleep_req, .asleep);
	// Clock and oscillator pin
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Oscillator pin toggles every cycle, parked low in reset
	always @(posedge clock)
		oscillator_input <= sys_rst ? 1'b0 : ~oscillator_input;
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic int oscillator_startup_counter(psrt_osc_t m);
		return (m <= OSC_HIGH_SPEED) ? 2048 : 0;
	endfunction
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic axw(logic [11:0] a, logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(negedge clock);
			t = {s_axi_awready, s_axi_wready, s_axi_bvalid};
			@(posedge clock);
			if (t[2]) s_axi_awvalid <= 1'b0;
			if (t[1]) s_axi_wvalid <= 1'b0;
		end while (!t[0]);
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic axr(logic [11:0] a);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(negedge clock);
			t = {s_axi_arready, 1'b0, s_axi_rvalid};
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clock);
			if (t[2]) s_axi_arvalid <= 1'b0;
		end while (!t[0]);
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rls();
		c = 0;
		do begin
			@(negedge clock);
			c++;
		end while (core_reset !== 1'b0);
		@(posedge clock);
	endtask
	task automatic results();
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog
	initial begin
		#400000;
		error_cnt++;
		results();
	end
	// Main sequence
	initial begin
		{sys_rst, master_clear_n, brownout_cmp} = 3'h6;
		{lv_tap_cmp, lv_ext_cmp, go_sleep, s_axi_awvalid} = 4'h0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		osc_mode = OSC_MEDIUM;
		lfsr = 32'h9FFE;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rls();
		chk(c >= oscillator_startup_counter(osc_mode) && c <= 2060, 1);
		for (int i = 0; i < 16; i++) begin
			lfsr = nxt(lfsr);
			axw(12'h000, {lfsr[31:6], 2'b00, i[3:0]});
			axr(12'h000);
			chk(rd, {28'h0, i[3:0]});
			chk({trip_level_out, ext_sense_sel}, {i[3:0], i[3:0] == 4'hF});
		end
		axr(12'h00C);
		chk(rr, 2'b10);
		chk(rd, 32'h0);
		lv_tap_cmp <= 1'b1;
		axw(12'h000, 32'h17);
		axr(12'h008);
		chk(rd[0], 0);
		c = 0;
		do begin
			axr(12'h000);
			c++;
		end while (rd[5] !== 1'b1 && c < 30);
		chk(c <= 12, 1);
		axr(12'h008);
		chk(rd[0], 1);
		lv_tap_cmp <= 1'b0;
		// Let the synchroniser drain so the clear is not overridden
		repeat (4) @(posedge clock);
		axw(12'h008, 32'h1);
		axw(12'h004, 32'h38);
		chk(core_irq, 0);
		lv_tap_cmp <= 1'b1;
		repeat (6) @(posedge clock);
		chk(core_irq, 1);
		lv_tap_cmp <= 1'b0;
		axw(12'h000, 32'h1F);
		axw(12'h008, 32'h1);
		lv_ext_cmp <= 1'b1;
		repeat (6) @(posedge clock);
		chk(core_irq, 1);
		lv_ext_cmp <= 1'b0;
		repeat (4) @(posedge clock);
		axw(12'h008, 32'h1);
		go_sleep <= 1'b1;
		wait (asleep === 1'b1);
		@(posedge clock);
		go_sleep <= 1'b0;
		lv_ext_cmp <= 1'b1;
		wait (core_wake === 1'b1);
		// Sequencer re-enters the start-up count at the next edge
		@(posedge clock);
		rls();
		chk(c >= 2040, 1);
		master_clear_n <= 1'b0;
		repeat (5) @(posedge clock);
		master_clear_n <= 1'b1;
		@(negedge clock);
		chk(core_reset, 0);
		@(posedge clock);
		axw(12'h004, 32'h03);
		brownout_cmp <= 1'b1;
		repeat (100) @(posedge clock);
		brownout_cmp <= 1'b0;
		repeat (5) @(posedge clock);
		chk(core_reset, 0);
		brownout_cmp <= 1'b1;
		repeat (20010) @(posedge clock);
		chk(core_reset, 1);
		brownout_cmp <= 1'b0;
		rls();
		chk(c >= 50 + oscillator_startup_counter(osc_mode), 1);
		osc_mode <= OSC_INT_RC;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		rls();
		chk(c < 20, 1);
		axr(12'h000);
		chk({detector_power, rd}, {1'b0, 32'h5});
		results();
	end
endmodule
